// >>> highway_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// highway controller: syncs, rx data, tx capture
// ----------------------------------------
module highway_model (
    input wire logic bclk,
    input wire logic go,
    input wire logic long_fs,
    input wire logic [7:0] rx_word,
    input wire logic tx_pcm,
    input wire logic tx_oe,
    output logic fs,
    output logic rx_pcm,
    output logic busy,
    output logic [7:0] tx_word,
    output logic [7:0] oe_bits
);
    int cnt = -1; // bit index in the frame, -1 idle
    int k;
    initial begin
        fs = 1'b0;
        rx_pcm = 1'b0;
        busy = 1'b0;
    end
    // sync rises just after a rising edge, so while bclk is high
    always @(posedge bclk) begin
        k = cnt;
        if (k < 0) begin
            rx_pcm <= ~rx_pcm; // released line keeps moving
            if (go) begin
                cnt <= 0;
                fs <= 1'b1;
                busy <= 1'b1;
            end
        end else begin
            cnt <= (k == 10) ? -1 : k + 1;
            busy <= (k != 10);
            if ((k == 0 && !long_fs) || k == 3) fs <= 1'b0; // one bit or four bits
            rx_pcm <= (k < 8) ? rx_word[7-k] : ~rx_pcm; // msb first
            if (k < 8) begin
                #20;
                tx_word[7-k] = tx_pcm; // taken a quarter bit after launch
                oe_bits[7-k] = tx_oe;
            end
        end
    end
endmodule
`default_nettype wire

// >>> pcm_bit_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two flip-flop level synchroniser, one chain per bit
module pcm_bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    if (WIDTH < 1) begin : g_bad_width
        $error("pcm_bit_sync needs WIDTH of at least 1");
    end

    // ----------------------------------------
    // per-bit chains
    // ----------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_q; // first stage, read only by second
        logic stab_q; // second stage
        // two stages, async clear to zero
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                meta_q <= 1'b0;
                stab_q <= 1'b0;
            end else begin
                meta_q <= async_in[i];
                stab_q <= meta_q;
            end
        end
        assign sync_out[i] = stab_q;
    end

endmodule

`default_nettype wire

// >>> pcm_fifo.sv
`timescale 1ns/1ps
`default_nettype none

// small flop fifo with valid/ready on both sides
module pcm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH); // index width

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_cfg
        $error("pcm_fifo needs a power-of-two DEPTH of 2 or more");
    end

    // ----------------------------------------
    // storage and pointers
    // ----------------------------------------
    logic [WIDTH-1:0] mem_q [DEPTH]; // entries
    logic [AW:0] wr_q; // write pointer with wrap bit
    logic [AW:0] rd_q; // read pointer with wrap bit

    wire empty = (wr_q == rd_q);
    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire push = in_valid && !full;
    wire pop = out_ready && !empty;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_q[rd_q[AW-1:0]];

    // pointer update
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end

    // entry write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!reset_n)
        full |=> (wr_q == $past(wr_q)))
        else $error("fifo write pointer moved while full");

endmodule

`default_nettype wire

// >>> pcm_port_defines.svh
`ifndef PCM_PORT_DEFINES_SVH
`define PCM_PORT_DEFINES_SVH

// ----------------------------------------
// slot framing
// ----------------------------------------
`define PCM_BITS 8
`define LONG_FS_MIN 3
`define TX_FIFO_DEPTH 4

// ----------------------------------------
// companded codes, a-law variant
// ----------------------------------------
`define ALAW_POS_FULL 8'haa
`define ALAW_ZERO 8'hd5
`define ALAW_ZERO_ALT 8'h55
`define ALAW_NEG_FULL 8'h2a

// ----------------------------------------
// companded codes, mu-law variant
// ----------------------------------------
`define MULAW_POS_FULL 8'h80
`define MULAW_ZERO 8'hff
`define MULAW_ZERO_ALT 8'h7f
`define MULAW_NEG_FULL 8'h00

// ----------------------------------------
// timing, reference clock in ns
// ----------------------------------------
`define REF_CLK_NS 40
`define PD_HOLD_NS 2000
`define PD_HOLD_CYC ((`PD_HOLD_NS + `REF_CLK_NS - 1) / `REF_CLK_NS)
`define ACT_WIN_NS 4000
`define ACT_WIN_CYC (`ACT_WIN_NS / `REF_CLK_NS)

`endif

// >>> pcm_port_pkg.sv
package pcm_port_pkg;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef logic [7:0] sample_t; // one companded sample

    // clocking mode taken from the master clock pin
    typedef enum logic [1:0] {
        MODE_OWN_MCLK = 2'b00, // pin carries its own master clock
        MODE_RX_FROM_TX = 2'b01, // pin low, tx master clock times rx
        MODE_POWERDOWN = 2'b10 // pin high, powered down
    } mode_e;

    // status seen by the user side
    typedef struct packed {
        mode_e mode; // clocking or power mode
        logic rate_2048; // master clock rate is 2.048 mhz
        logic rx_bitclk_ext; // select pin toggles as rx bit clock
        logic long_frame; // last tx frame sync was long
    } status_s;

endpackage

// >>> pcm_serial_port.sv
// Function
// - slot indicator pulled low during tx slot
// - master clock pin: high powers down, low shares
// - static select pin picks rate, shared clock
// - launch tx bits on rising bit clock
// - release tx output from falling edge inside last bit
// - sample rx bits on falling bit clock
// - idle code per law when no user word waits
`timescale 1ns/1ps
`default_nettype none
`include "pcm_port_defines.svh"

module pcm_serial_port #(
    parameter bit ALAW = 1'b1,
    parameter int PD_HOLD = `PD_HOLD_CYC,
    parameter int ACT_WIN = `ACT_WIN_CYC,
    parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic tx_bitclk,
    input wire logic tx_frame_sync,
    input wire logic rx_frame_sync,
    input wire logic rx_pcm,
    input wire logic rx_bitclk_or_rate_select,
    input wire logic rx_masterclk_or_powerdown,
    output logic tx_pcm_data,
    output logic tx_pcm_oe,
    input wire logic tx_slot_indicator_n_in,
    output logic tx_slot_indicator_n_drive,
    output logic tx_slot_indicator_n_oe,
    input wire pcm_port_pkg::sample_t tx_sample,
    input wire logic tx_sample_valid,
    output logic tx_sample_ready,
    output pcm_port_pkg::sample_t rx_sample,
    output logic rx_sample_valid,
    output pcm_port_pkg::status_s status
);
    import pcm_port_pkg::*;

    // ----------------------------------------
    // constants and elaboration checks
    // ----------------------------------------
    localparam logic [3:0] LAST_BIT = 4'(`PCM_BITS); // bits per slot
    localparam logic [3:0] LONG_MIN = 4'(`LONG_FS_MIN); // long sync length
    localparam logic [7:0] HOLD_CNT = 8'(PD_HOLD); // steady pin cycles
    localparam logic [7:0] WIN_CNT = 8'(ACT_WIN); // select activity window
    localparam sample_t IDLE_CODE = ALAW ? `ALAW_ZERO : `MULAW_ZERO; // zero input

    if (PD_HOLD < 2 || PD_HOLD > 255 || ACT_WIN < 2 || ACT_WIN > 255) begin : g_bad_cnt
        $error("PD_HOLD and ACT_WIN must lie in 2..255");
    end

    // ----------------------------------------
    // crossings
    // ----------------------------------------
    logic give_tog_q; // ref: new tx word offered
    logic pd_ref_q; // ref: powered down
    sample_t hold_q; // ref: tx word held for the link
    logic take_tog_q; // link: tx word taken
    logic rx_tog_q; // link: rx word ready
    logic long_q; // link: last sync was long
    sample_t rx_word_q; // link: last rx word
    logic link_rst_n, give_s, pd_link; // link side of crossings
    logic long_s, rx_s, take_s, mclk_s, rsel_s; // ref side of crossings

    // reset release, offer toggle and power-down into the link domain
    pcm_bit_sync #(.WIDTH(3)) u_link_sync (
        .clk(tx_bitclk),
        .reset_n(reset_n),
        .async_in({1'b1, give_tog_q, pd_ref_q}),
        .sync_out({link_rst_n, give_s, pd_link})
    );

    // link toggles, long flag and both dual-use pins into the ref domain
    pcm_bit_sync #(.WIDTH(5)) u_ref_sync (
        .clk(ref_clk),
        .reset_n(reset_n),
        .async_in({long_q, rx_tog_q, take_tog_q, rx_masterclk_or_powerdown, rx_bitclk_or_rate_select}),
        .sync_out({long_s, rx_s, take_s, mclk_s, rsel_s})
    );

    // ----------------------------------------
    // ref domain: pin mode decoding
    // ----------------------------------------
    logic mclk_prev_q, rsel_prev_q; // last pin levels
    logic [7:0] mclk_cnt_q, rsel_cnt_q; // cycles without a change
    mode_e mode_q; // decoded clocking mode

    wire mclk_chg = (mclk_s != mclk_prev_q);
    wire rsel_chg = (rsel_s != rsel_prev_q);
    wire [7:0] mclk_cnt_d = mclk_chg ? 8'h00 : ((mclk_cnt_q == HOLD_CNT) ? mclk_cnt_q : mclk_cnt_q + 8'h01);
    wire [7:0] rsel_cnt_d = rsel_chg ? 8'h00 : ((rsel_cnt_q == WIN_CNT) ? rsel_cnt_q : rsel_cnt_q + 8'h01);
    // steady high powers down, steady low shares tx master clock
    wire mode_e mode_d = (mclk_cnt_d == HOLD_CNT) ? (mclk_s ? MODE_POWERDOWN : MODE_RX_FROM_TX)
                       : (mclk_chg ? MODE_OWN_MCLK : mode_q);
    wire rsel_clocked = (rsel_cnt_q != WIN_CNT);
    // static level picks rate, clocked pin falls back to fixed rate
    wire rate_d = rsel_clocked ? ALAW : (rsel_s ^ !ALAW);

    // pin level and steady counters
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mclk_prev_q <= 1'b0;
            rsel_prev_q <= 1'b0;
            mclk_cnt_q <= 8'h00;
            rsel_cnt_q <= 8'h00;
        end else begin
            mclk_prev_q <= mclk_s;
            rsel_prev_q <= rsel_s;
            mclk_cnt_q <= mclk_cnt_d;
            rsel_cnt_q <= rsel_cnt_d;
        end
    end

    // mode, power-down level and status
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= MODE_OWN_MCLK;
            pd_ref_q <= 1'b0;
            status <= '0;
        end else begin
            mode_q <= mode_d;
            pd_ref_q <= (mode_q == MODE_POWERDOWN);
            status <= '{mode: mode_q, rate_2048: rate_d, rx_bitclk_ext: rsel_clocked, long_frame: long_s};
        end
    end

    // ----------------------------------------
    // ref domain: tx word offer and rx word delivery
    // ----------------------------------------
    sample_t fifo_data; // head of tx fifo
    logic fifo_valid; // tx fifo not empty
    logic rx_seen_q; // last rx toggle handled
    wire hold_free = (give_tog_q == take_s); // link took the held word
    wire offer = fifo_valid && hold_free;

    // user samples wait here; drained once per frame by the link
    pcm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk(ref_clk),
        .reset_n(reset_n),
        .in_valid(tx_sample_valid),
        .in_ready(tx_sample_ready),
        .in_data(tx_sample),
        .out_valid(fifo_valid),
        .out_ready(hold_free),
        .out_data(fifo_data)
    );

    // load held word and toggle offer
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            give_tog_q <= 1'b0;
            hold_q <= 8'h00;
        end else if (offer) begin
            give_tog_q <= !give_tog_q;
            hold_q <= fifo_data;
        end
    end

    // rx word stands a whole frame in the link, safe to copy here
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_seen_q <= 1'b0;
            rx_sample <= 8'h00;
            rx_sample_valid <= 1'b0;
        end else begin
            rx_seen_q <= rx_s;
            rx_sample_valid <= (rx_s != rx_seen_q);
            if (rx_s != rx_seen_q) begin
                rx_sample <= rx_word_q;
            end
        end
    end

    // ----------------------------------------
    // link domain: transmit slot
    // ----------------------------------------
    logic tx_fs_prev_q; // sync level at last rising edge
    logic slot_q; // inside own tx slot
    logic [3:0] bit_cnt_q; // bit number being sent, 1..8
    sample_t tx_sh_q; // tx shift register
    sample_t tx_sent_q; // word of current slot
    sample_t next_word_q; // word waiting for next slot
    logic next_valid_q; // next_word_q holds a user word
    logic last_neg_q; // falling edge inside last bit seen
    logic [3:0] fs_len_q; // sync length in bit clocks

    // slot opens on first rising edge that sees the sync high
    wire tx_fs_start = tx_frame_sync && !tx_fs_prev_q && !pd_link;
    wire take_new = (give_s != take_tog_q) && !next_valid_q && !tx_fs_start;
    // no user word ready: send the zero-input code
    wire sample_t frame_word = next_valid_q ? next_word_q : IDLE_CODE;
    wire slot_end = slot_q && ((bit_cnt_q == LAST_BIT) || pd_link);

    // slot state and bit counter, rising edge
    always_ff @(posedge tx_bitclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_fs_prev_q <= 1'b0;
            slot_q <= 1'b0;
            bit_cnt_q <= 4'h0;
        end else begin
            tx_fs_prev_q <= tx_frame_sync;
            if (tx_fs_start) begin
                slot_q <= 1'b1;
                bit_cnt_q <= 4'h1;
            end else if (slot_end) begin
                slot_q <= 1'b0;
                bit_cnt_q <= 4'h0;
            end else if (slot_q) begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
    end

    // msb first, next bit launched each rising edge
    always_ff @(posedge tx_bitclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_sh_q <= 8'h00;
            tx_sent_q <= 8'h00;
        end else if (tx_fs_start) begin
            tx_sh_q <= frame_word;
            tx_sent_q <= frame_word;
        end else if (slot_q) begin
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        end
    end

    // take offered word, free it when a slot starts
    always_ff @(posedge tx_bitclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            take_tog_q <= 1'b0;
            next_word_q <= 8'h00;
            next_valid_q <= 1'b0;
        end else if (tx_fs_start) begin
            next_valid_q <= 1'b0;
        end else if (take_new) begin
            take_tog_q <= give_s;
            next_word_q <= hold_q;
            next_valid_q <= 1'b1;
        end
    end

    // frame sync length, long when three or more bit clocks
    always_ff @(posedge tx_bitclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            fs_len_q <= 4'h0;
            long_q <= 1'b0;
        end else if (tx_frame_sync) begin
            fs_len_q <= (fs_len_q == 4'hf) ? fs_len_q : fs_len_q + 4'h1;
        end else if (tx_fs_prev_q) begin
            fs_len_q <= 4'h0;
            long_q <= (fs_len_q >= LONG_MIN);
        end
    end

    // falling edge in last bit ends the drive
    always_ff @(negedge tx_bitclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            last_neg_q <= 1'b0;
        end else begin
            last_neg_q <= slot_q && (bit_cnt_q == LAST_BIT);
        end
    end

    // output stages: data tri-state, indicator open drain
    wire drive_en = slot_q && !last_neg_q;
    assign tx_pcm_data = tx_sh_q[7];
    assign tx_pcm_oe = drive_en;
    assign tx_slot_indicator_n_drive = 1'b0;
    assign tx_slot_indicator_n_oe = drive_en;

    // ----------------------------------------
    // link domain: receive slot
    // ----------------------------------------
    logic rx_fs_prev_q; // rx sync level at last rising edge
    logic rx_slot_q; // inside rx slot
    logic [3:0] rx_cnt_q; // rx bit number, 1..8
    sample_t rx_sh_q; // rx shift register

    wire rx_fs_start = rx_frame_sync && !rx_fs_prev_q && !pd_link;
    wire rx_last = rx_slot_q && (rx_cnt_q == LAST_BIT);

    // rx slot framing, rising edge
    always_ff @(posedge tx_bitclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rx_fs_prev_q <= 1'b0;
            rx_slot_q <= 1'b0;
            rx_cnt_q <= 4'h0;
        end else begin
            rx_fs_prev_q <= rx_frame_sync;
            if (rx_fs_start) begin
                rx_slot_q <= 1'b1;
                rx_cnt_q <= 4'h1;
            end else if (rx_last || pd_link) begin
                rx_slot_q <= 1'b0;
                rx_cnt_q <= 4'h0;
            end else if (rx_slot_q) begin
                rx_cnt_q <= rx_cnt_q + 4'h1;
            end
        end
    end

    // sample rx bit on falling edge, msb first
    always_ff @(negedge tx_bitclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rx_sh_q <= 8'h00;
            rx_word_q <= 8'h00;
            rx_tog_q <= 1'b0;
        end else if (rx_slot_q) begin
            rx_sh_q <= {rx_sh_q[6:0], rx_pcm};
            if (rx_last) begin
                rx_word_q <= {rx_sh_q[6:0], rx_pcm};
                rx_tog_q <= !rx_tog_q;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_slot_ind_low: assert property (@(posedge tx_bitclk) disable iff (!link_rst_n)
        $rose(slot_q) |-> tx_slot_indicator_n_oe && !tx_slot_indicator_n_drive && tx_pcm_oe)
        else $error("slot indicator not pulled low at slot start");
    a_slot_readback: assert property (@(posedge tx_bitclk) disable iff (!link_rst_n)
        tx_slot_indicator_n_oe |-> !tx_slot_indicator_n_in)
        else $error("slot indicator pin high while pulled low");
    a_first_bit_launch: assert property (@(posedge tx_bitclk) disable iff (!link_rst_n)
        (tx_frame_sync && !tx_fs_prev_q && !pd_link) |=> slot_q && bit_cnt_q == 4'h1)
        else $error("first bit not launched on sync rising edge");
    a_msb_first_order: assert property (@(posedge tx_bitclk) disable iff (!link_rst_n)
        ($rose(slot_q) && !pd_link) |-> tx_pcm_data == tx_sent_q[7] ##7 tx_pcm_data == tx_sent_q[0])
        else $error("tx bits not sent msb first");
    a_eight_bit_slot: assert property (@(posedge tx_bitclk) disable iff (!link_rst_n || pd_link)
        $rose(slot_q) |-> slot_q[*8] ##1 !slot_q)
        else $error("tx slot not eight bits long");
    a_hiz_after_slot: assert property (@(posedge tx_bitclk) disable iff (!link_rst_n)
        (slot_q && bit_cnt_q == LAST_BIT) |=> !tx_pcm_oe && !tx_slot_indicator_n_oe)
        else $error("tx output still driven after last bit");
    a_rx_fall_sample: assert property (@(negedge tx_bitclk) disable iff (!link_rst_n)
        rx_last |=> rx_word_q[0] == $past(rx_pcm) && rx_tog_q != $past(rx_tog_q))
        else $error("rx bit not taken on falling edge");
    a_idle_code_sent: assert property (@(posedge tx_bitclk) disable iff (!link_rst_n)
        (tx_fs_start && !next_valid_q) |=> tx_sent_q == IDLE_CODE)
        else $error("idle code not sent without user word");
    a_pd_quiet: assert property (@(posedge tx_bitclk) disable iff (!link_rst_n)
        pd_link |=> !slot_q && !tx_pcm_oe && !tx_slot_indicator_n_oe)
        else $error("outputs driven while powered down");
    a_pd_mode_entry: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (mclk_s && !mclk_chg && mclk_cnt_q == HOLD_CNT - 8'h01) |=> mode_q == MODE_POWERDOWN ##1 pd_ref_q)
        else $error("steady high pin did not power down");
    a_rate_from_pin: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!rsel_clocked && !rsel_chg) |=> status.rate_2048 == ($past(rsel_s) ^ !ALAW))
        else $error("rate not taken from select pin level");
    a_rx_delivered: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (rx_s != rx_seen_q) |=> rx_sample_valid ##1 !rx_sample_valid)
        else $error("rx sample pulse wrong");

    c_tx_slot: cover property (@(posedge tx_bitclk) disable iff (!link_rst_n) $fell(slot_q) && next_valid_q);
    c_rx_word: cover property (@(posedge ref_clk) disable iff (!reset_n) rx_sample_valid);
    c_powerdown: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(pd_ref_q));
    c_long_frame: cover property (@(posedge ref_clk) disable iff (!reset_n) status.long_frame);

endmodule

`default_nettype wire

// >>> pcm_serial_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcm_port_defines.svh"
module pcm_serial_port_tb;
    import pcm_port_pkg::*;
    logic ref_clk = 1'b0;
    logic bclk = 1'b0;
    logic reset_n = 1'b0;
    logic pd_pin = 1'b0;
    logic sel_pin = 1'b1; // static rate select level
    logic go = 1'b0;
    logic long_fs = 1'b0;
    logic [7:0] rx_word = 8'h00;
    sample_t tx_sample = 8'h00;
    logic tx_valid = 1'b0;
    wire logic fs, rx_pcm, busy, tx_data, tx_oe, ind_drive, ind_oe, tx_ready, rx_valid;
    wire logic [7:0] tx_word, oe_bits;
    wire sample_t rx_sample;
    wire status_s status;
    logic [31:0] seed = 32'hd60eec8f;
    int bad_count = 0;
    int total_checks = 0;
    logic [7:0] exp_q[$]; // words owed to the highway
    logic [7:0] got_q[$]; // words handed to the user
    // ----------------------------------------
    // clocks and design
    // ----------------------------------------
    always #20 ref_clk = ~ref_clk;
    // bit clock doubles as tx master clock, bench rate
    initial begin
        #13;
        forever #40 bclk = ~bclk;
    end
    pcm_serial_port #(.PD_HOLD(4), .ACT_WIN(8)) dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .tx_bitclk(bclk), .tx_frame_sync(fs),
        .rx_frame_sync(fs), .rx_pcm(rx_pcm), .rx_bitclk_or_rate_select(sel_pin),
        .rx_masterclk_or_powerdown(pd_pin), .tx_pcm_data(tx_data), .tx_pcm_oe(tx_oe),
        .tx_slot_indicator_n_in(ind_oe ? ind_drive : 1'b1), .tx_slot_indicator_n_drive(ind_drive),
        .tx_slot_indicator_n_oe(ind_oe), .tx_sample(tx_sample), .tx_sample_valid(tx_valid),
        .tx_sample_ready(tx_ready), .rx_sample(rx_sample), .rx_sample_valid(rx_valid), .status(status));
    highway_model hw (.bclk(bclk), .go(go), .long_fs(long_fs), .rx_word(rx_word), .tx_pcm(tx_data),
        .tx_oe(tx_oe && ind_oe && !ind_drive), .fs(fs), .rx_pcm(rx_pcm), .busy(busy),
        .tx_word(tx_word), .oe_bits(oe_bits));
    always @(posedge ref_clk) if (rx_valid === 1'b1) got_q.push_back(rx_sample);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // offer words every cycle, refused ones are not owed
    task automatic fill();
        for (int i = 0; i < 10; i++) begin
            @(negedge ref_clk);
            tx_sample = rnd();
            tx_valid = 1'b1;
            if (tx_ready === 1'b1) exp_q.push_back(tx_sample);
        end
        @(negedge ref_clk);
        tx_valid = 1'b0;
    endtask
    // one frame both ways, then compare with the model
    task automatic frame(logic lng);
        logic [7:0] exp_tx;
        repeat (6) @(posedge bclk);
        got_q.delete();
        @(negedge ref_clk);
        long_fs = lng;
        rx_word = rnd();
        go = 1'b1;
        @(posedge busy);
        @(negedge ref_clk);
        go = 1'b0;
        @(negedge busy);
        repeat (10) @(posedge ref_clk);
        check("oe idle", {7'h0, tx_oe}, 8'h00);
        if (status.mode === MODE_POWERDOWN) begin
            check("tx oe", oe_bits, 8'h00);
            check("rx count", 8'(got_q.size()), 8'h00);
        end else begin
            exp_tx = (exp_q.size() > 0) ? exp_q.pop_front() : `ALAW_ZERO;
            check("tx word", tx_word, exp_tx);
            check("tx oe", oe_bits, 8'hff);
            check("rx word", (got_q.size() > 0) ? got_q[0] : 8'hxx, rx_word);
            check("long flag", {7'h0, status.long_frame}, {7'h0, lng});
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (10) @(negedge ref_clk);
        reset_n = 1'b1;
        frame(1'b0);
        check("rate", {7'h0, status.rate_2048}, 8'h01);
        check("sel clocked", {7'h0, status.rx_bitclk_ext}, 8'h00);
        $display("test idle_code done");
        fill();
        check("ready full", {7'h0, tx_ready}, 8'h00);
        for (int i = 0; i < 6; i++) frame(i[0]);
        $display("test fill_drain done");
        @(negedge ref_clk);
        pd_pin = 1'b1;
        sel_pin = 1'b0;
        repeat (30) @(negedge ref_clk);
        check("mode", {6'h0, status.mode}, {6'h0, MODE_POWERDOWN});
        check("rate", {7'h0, status.rate_2048}, 8'h00);
        frame(1'b0);
        @(negedge ref_clk);
        pd_pin = 1'b0;
        repeat (30) @(negedge ref_clk);
        check("mode", {6'h0, status.mode}, {6'h0, MODE_RX_FROM_TX});
        frame(1'b1);
        $display("test powerdown done");
        test_done();
    end
    initial begin
        #200000;
        bad_count++;
        test_done();
    end
endmodule
`default_nettype wire
